// [hw/disk_cmd_pkg.sv]
// Overview of operation
// - Alert output is active whenever any of the four fault or status conditions holds.
// - Write conflict sets when selected with read gate and write gate both active.
// - Write conflict clears only on loading function 0101, modifier 0000 into word high.
// - Parity source is serial input while receiving, word high top bit while sending.
// - Accumulator toggles per one bit; inverted result flags even-count commands bad.
// - A command passing parity raises the interrupt to the microcontroller.
// - When sending, the accumulator output is the parity bit after both bytes.
// - Accumulator advances only on the shift strobe: request while selected.
// - Accumulator clears when the interrupt is raised or a link abort is detected.
// - Link abort sets when the drive selection drops while transfer-in-progress is set, before all seventeen bits moved.
// - Transfer-in-progress sets after first bit in, clears after seventeenth bit.
// - Link abort flag is a clocked register cleared by a fault clear signal.
// - External status change enters through a buffered input into the alert logic.
// - Fault register: parity bit 0, link abort bit 4, write conflict bit 7.
// - Two address lines select word high, word low, fault flags or done trigger.
// - Both data registers capture the command shifted in from the serial input.
// - Request-data answers shift word high top bit out, then the generated parity.
// - Command done asserts once all seventeen outgoing response bits are transferred.
// - Writing all zeros to the done trigger register asserts command done.
// - Done trigger is write-only, fault flags read-only; readback mux holds three registers.
// - Controller requests when a bit is valid; device acknowledges once it took it.
// - Each command is seventeen serial bits: sixteen data bits plus one parity bit.
// - Device is selected only when drive select code equals its strapped drive number.
package disk_cmd_pkg;
	localparam logic [1:0] ADDR_WORD_HIGH  = 2'h0;
	localparam logic [1:0] ADDR_WORD_LOW   = 2'h1;
	localparam logic [1:0] ADDR_FAULTS     = 2'h2;
	localparam logic [1:0] ADDR_DONE_TRIG  = 2'h3;
	localparam int         FAULT_PARITY    = 0;
	localparam int         FAULT_ABORT     = 4;
	localparam int         FAULT_CONFLICT  = 7;
	localparam logic [3:0] FUNC_CONTROL    = 4'h5;
	localparam logic [3:0] MOD_RESET_ATTN  = 4'h0;
	localparam logic [3:0] FUNC_REQ_STATUS = 4'h2;
	localparam logic [3:0] FUNC_REQ_CONFIG = 4'h3;
	localparam logic [4:0] DATA_BITS       = 5'h10;
	localparam logic [4:0] LAST_BIT_INDEX  = 5'h10;
	localparam logic [4:0] COUNT_ZERO      = 5'h00;
	localparam logic [7:0] BYTE_ZERO       = 8'h00;
	localparam int         WORD_BITS       = 16;
	localparam int         FIFO_DEPTH      = 4;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} cmd_word_s;

	typedef enum logic [2:0] {
		LINK_IDLE = 3'b001,
		LINK_RECV = 3'b010,
		LINK_SEND = 3'b100
	} link_state_e;

	function automatic logic [3:0] funcCode(input logic [7:0] high);
		funcCode = high[7:4];
	endfunction

	function automatic logic isRequestData(input logic [7:0] high);
		isRequestData = (funcCode(high) == FUNC_REQ_STATUS) || (funcCode(high) == FUNC_REQ_CONFIG);
	endfunction
endpackage

// [hw/disk_serial_command_error_unit.sv]
`timescale 1ns/1ps
// ****************************************
// command word fifo
// ****************************************
module cmd_word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wrPtr;
	logic [PW:0]      rdPtr;
	logic             full;
	logic             empty;

	// depth must be a power of two for the wrap bit to work
	assign empty    = (wrPtr == rdPtr);
	assign full     = (wrPtr[PW] != rdPtr[PW]) && (wrPtr[PW-1:0] == rdPtr[PW-1:0]);
	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = mem[rdPtr[PW-1:0]];

	always_ff @(posedge clock) begin
		if (inValid && !full) begin
			mem[wrPtr[PW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (inValid && !full) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (outReady && !empty) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end
endmodule

// ****************************************
// serial command and fault unit
// ****************************************
module disk_serial_command_error_unit
	import disk_cmd_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic [2:0] driveSelect,
	input  wire logic [2:0] driveStrap,
	input  wire logic       bitValidReq,
	input  wire logic       serialCommandIn,
	input  wire logic       readGateFromHost,
	input  wire logic       writeGateFromHost,
	input  wire logic       externalStatusInput,
	input  wire logic       faultClear,
	input  wire logic [1:0] regAddr,
	input  wire logic       readStrobe,
	input  wire logic       writeStrobe,
	input  wire logic [7:0] writeData,
	output logic      [7:0] readData,
	output logic            bitTakenAck,
	output logic            statusDataOut,
	output logic            alertToHost,
	output logic            commandDone,
	output logic            cmdInterrupt
);
	link_state_e state;
	cmd_word_s   fifoIn;
	cmd_word_s   fifoOut;
	logic [7:0]  commandWordHigh;
	logic [7:0]  commandWordLow;
	logic [15:0] rxWord;
	logic [4:0]  bitCount;
	logic        driveChosen;
	logic        prevChosen;
	logic        shiftStrobe;
	logic        sending;
	logic        lastBit;
	logic        frameEnd;
	logic        paritySourceMux;
	logic        parityAccumulator;
	logic        parityAccumClear;
	logic        rxGood;
	logic        parityBad;
	logic        linkAbortFault;
	logic        abortDetect;
	logic        writeConflictFault;
	logic        externalStatusChange;
	logic        transferInProgress;
	logic        txArmed;
	logic        requestPending;
	logic        fifoInValid;
	logic        fifoInReady;
	logic        fifoOutValid;
	logic        fifoOutReady;
	logic        pop;
	logic        rxStall;
	logic [7:0]  faultFlags;

	// ****************************************
	// selection and link handshake
	// ****************************************
	assign driveChosen = (driveSelect == driveStrap);
	assign sending     = (state == LINK_SEND) || ((state == LINK_IDLE) && txArmed);
	// a full fifo holds off receive frames so no command is dropped
	assign rxStall     = !sending && !fifoInReady;
	assign shiftStrobe = bitValidReq && driveChosen && !bitTakenAck && !rxStall;
	assign lastBit     = (bitCount == LAST_BIT_INDEX);
	assign frameEnd    = shiftStrobe && lastBit;
	assign transferInProgress = (state != LINK_IDLE);
	// losing the selection mid frame ends the frame early
	assign abortDetect = transferInProgress && prevChosen && !driveChosen;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bitTakenAck <= 1'b0;
		end else if (shiftStrobe) begin
			bitTakenAck <= 1'b1;
		end else if (!bitValidReq) begin
			bitTakenAck <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prevChosen <= 1'b0;
		end else begin
			prevChosen <= driveChosen;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= LINK_IDLE;
		end else begin
			unique case (state)
				LINK_IDLE: begin
					if (shiftStrobe) begin
						state <= txArmed ? LINK_SEND : LINK_RECV;
					end
				end
				LINK_RECV, LINK_SEND: begin
					if (abortDetect || frameEnd) begin
						state <= LINK_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bitCount <= COUNT_ZERO;
		end else if (abortDetect || frameEnd) begin
			bitCount <= COUNT_ZERO;
		end else if (shiftStrobe) begin
			bitCount <= bitCount + 5'h01;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rxWord <= 16'h0000;
		end else if (shiftStrobe && !sending && (bitCount < DATA_BITS)) begin
			rxWord <= {rxWord[14:0], serialCommandIn};
		end
	end

	// ****************************************
	// parity checker and generator
	// ****************************************
	assign paritySourceMux  = sending ? commandWordHigh[7] : serialCommandIn;
	// the raise of the interrupt only happens between frames, so it never cuts one
	assign parityAccumClear = pop || abortDetect || frameEnd;
	assign rxGood           = parityAccumulator ^ serialCommandIn;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			parityAccumulator <= 1'b0;
		end else if (parityAccumClear) begin
			parityAccumulator <= 1'b0;
		end else if (shiftStrobe) begin
			parityAccumulator <= parityAccumulator ^ paritySourceMux;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			parityBad <= 1'b0;
		end else if (frameEnd && !sending && !rxGood) begin
			parityBad <= 1'b1;
		end else if (faultClear) begin
			parityBad <= 1'b0;
		end
	end

	// ****************************************
	// faults and alert
	// ****************************************
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			linkAbortFault <= 1'b0;
		end else if (abortDetect) begin
			linkAbortFault <= 1'b1;
		end else if (faultClear) begin
			linkAbortFault <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			writeConflictFault <= 1'b0;
		end else if (driveChosen && readGateFromHost && writeGateFromHost) begin
			writeConflictFault <= 1'b1;
		end else if (pop && (funcCode(fifoOut.high) == FUNC_CONTROL)
				&& (fifoOut.high[3:0] == MOD_RESET_ATTN)) begin
			writeConflictFault <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			externalStatusChange <= 1'b0;
		end else begin
			externalStatusChange <= externalStatusInput;
		end
	end

	assign alertToHost = writeConflictFault || parityBad || linkAbortFault
		|| externalStatusChange;

	always_comb begin
		faultFlags                 = BYTE_ZERO;
		faultFlags[FAULT_PARITY]   = parityBad;
		faultFlags[FAULT_ABORT]    = linkAbortFault;
		faultFlags[FAULT_CONFLICT] = writeConflictFault;
	end

	// ****************************************
	// command buffer
	// ****************************************
	assign fifoInValid  = frameEnd && !sending && rxGood;
	assign fifoIn       = rxWord;
	// next command only loads between frames and after the last was read
	assign fifoOutReady = !cmdInterrupt && (state == LINK_IDLE) && !txArmed && !shiftStrobe;
	assign pop          = fifoOutReady && fifoOutValid;

	cmd_word_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) commandBuffer (
		.clock   (clock),
		.arst_n  (arst_n),
		.inValid (fifoInValid),
		.inReady (fifoInReady),
		.inData  (fifoIn),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData (fifoOut)
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cmdInterrupt <= 1'b0;
		end else if (pop) begin
			cmdInterrupt <= 1'b1;
		end else if (readStrobe && (regAddr == ADDR_WORD_LOW)) begin
			cmdInterrupt <= 1'b0;
		end
	end

	// ****************************************
	// data registers and transmit
	// ****************************************
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			commandWordHigh <= BYTE_ZERO;
			commandWordLow  <= BYTE_ZERO;
		end else if (shiftStrobe && sending) begin
			commandWordHigh <= {commandWordHigh[6:0], commandWordLow[7]};
			commandWordLow  <= {commandWordLow[6:0], 1'b0};
		end else if (pop) begin
			commandWordHigh <= fifoOut.high;
			commandWordLow  <= fifoOut.low;
		end else if (writeStrobe && (regAddr == ADDR_WORD_HIGH)) begin
			commandWordHigh <= writeData;
		end else if (writeStrobe && (regAddr == ADDR_WORD_LOW)) begin
			commandWordLow <= writeData;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			requestPending <= 1'b0;
		end else if (pop) begin
			requestPending <= isRequestData(fifoOut.high);
		end else if (writeStrobe && (regAddr == ADDR_WORD_LOW)) begin
			requestPending <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			txArmed <= 1'b0;
		end else if (writeStrobe && (regAddr == ADDR_WORD_LOW) && requestPending) begin
			txArmed <= 1'b1;
		end else if (shiftStrobe) begin
			txArmed <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			statusDataOut <= 1'b0;
		end else if (shiftStrobe && sending) begin
			statusDataOut <= lastBit ? parityAccumulator : commandWordHigh[7];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			commandDone <= 1'b0;
		end else if (frameEnd && sending) begin
			commandDone <= 1'b1;
		end else if (writeStrobe && (regAddr == ADDR_DONE_TRIG) && (writeData == BYTE_ZERO)) begin
			commandDone <= 1'b1;
		end else if (shiftStrobe && (state == LINK_IDLE)) begin
			commandDone <= 1'b0;
		end
	end

	// ****************************************
	// register readback
	// ****************************************
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			readData <= BYTE_ZERO;
		end else if (readStrobe) begin
			unique case (regAddr)
				ADDR_WORD_HIGH: readData <= commandWordHigh;
				ADDR_WORD_LOW:  readData <= commandWordLow;
				ADDR_FAULTS:    readData <= faultFlags;
				ADDR_DONE_TRIG: readData <= BYTE_ZERO;
			endcase
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence sendLastBit;
		shiftStrobe && sending && lastBit;
	endsequence

	sequence zeroDoneWrite;
		writeStrobe && (regAddr == ADDR_DONE_TRIG) && (writeData == BYTE_ZERO);
	endsequence

	alert_sources_a: assert property (
		(parityBad || linkAbortFault || writeConflictFault) |-> alertToHost)
		else $error("alert low while a fault is set");
	conflict_set_a: assert property (
		driveChosen && readGateFromHost && writeGateFromHost |=> writeConflictFault)
		else $error("write conflict not set");
	conflict_keep_a: assert property (
		writeConflictFault && !pop |=> writeConflictFault)
		else $error("write conflict cleared without reset command");
	accum_clear_a: assert property (
		abortDetect || pop |=> !parityAccumulator)
		else $error("parity accumulator not cleared");
	accum_still_a: assert property (
		!shiftStrobe && !parityAccumClear |=> $stable(parityAccumulator))
		else $error("parity accumulator moved without shift");
	parity_bad_a: assert property (
		frameEnd && !sending && !rxGood |=> parityBad && !fifoInValid[*1])
		else $error("bad parity not flagged");
	abort_flag_a: assert property (
		abortDetect |=> linkAbortFault && !transferInProgress && (bitCount == COUNT_ZERO))
		else $error("abort not recorded");
	progress_a: assert property (
		shiftStrobe && (state == LINK_IDLE) |=> transferInProgress)
		else $error("transfer flag not set after first bit");
	pop_int_a: assert property (
		pop |=> cmdInterrupt && (commandWordHigh == $past(fifoOut.high)))
		else $error("command load without interrupt");
	send_done_a: assert property (
		sendLastBit |=> commandDone && (statusDataOut == $past(parityAccumulator)))
		else $error("response end without command done");
	write_done_a: assert property (
		zeroDoneWrite |=> commandDone)
		else $error("zero write did not raise command done");
	ack_hold_a: assert property (
		shiftStrobe |=> bitTakenAck ##1 (bitTakenAck || !$past(bitValidReq)))
		else $error("acknowledge dropped while request held");
	trig_read_a: assert property (
		readStrobe && (regAddr == ADDR_DONE_TRIG) |=> readData == BYTE_ZERO)
		else $error("done trigger read back nonzero");
endmodule

// [test/disk_ctrl_model.sv]
`timescale 1ns/1ps
// ****************************************
// disk controller side of the command link
// ****************************************
module disk_ctrl_model (
	input  wire logic clock,
	input  wire logic bitTakenAck,
	input  wire logic statusDataOut,
	output logic      bitValidReq,
	output logic      serialCommandIn
);
	initial begin
		bitValidReq = 1'b0;
		serialCommandIn = 1'b0;
	end

	// one bit each way per handshake; ok stays low if the device never answers
	task automatic xfer(input logic txBit, output logic rxBit, output bit ok);
		ok = 1'b0;
		rxBit = 1'b0;
		@(posedge clock);
		#1;
		serialCommandIn = txBit;
		bitValidReq = 1'b1;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clock);
			#1;
			if (bitTakenAck === 1'b1) begin
				ok = 1'b1;
				rxBit = statusDataOut;
			end
		end
		bitValidReq = 1'b0;
		// a released line must not keep showing the old bit
		serialCommandIn = ~txBit;
		for (int i = 0; i < 40 && bitTakenAck !== 1'b0; i++) begin
			@(posedge clock);
			#1;
		end
	endtask

	task automatic frame(input logic [16:0] txd, input int n, output logic [16:0] rxd,
			output bit ok);
		logic b;
		rxd = 17'h00000;
		ok = 1'b1;
		for (int i = 16; i > 16 - n && ok; i--) begin
			xfer(txd[i], b, ok);
			rxd[i] = b;
		end
	endtask
endmodule

// [test/test_disk_serial_command_error_unit.sv]
`timescale 1ns/1ps
module test_disk_serial_command_error_unit
	import disk_cmd_pkg::*;
;
	logic        clock;
	logic        arst_n;
	logic [2:0]  driveSelect;
	logic        readGateFromHost;
	logic        writeGateFromHost;
	logic        externalStatusInput;
	logic        faultClear;
	logic [1:0]  regAddr;
	logic        readStrobe;
	logic        writeStrobe;
	logic [7:0]  writeData;
	logic [7:0]  readData;
	logic        bitTakenAck;
	logic        statusDataOut;
	logic        alertToHost;
	logic        commandDone;
	logic        cmdInterrupt;
	logic        bitValidReq;
	logic        serialCommandIn;
	logic [16:0] rx;
	bit          ok;
	int          miscompares;
	int          cmp_count;

	disk_serial_command_error_unit disk_serial_command_error_unit_i (
		.clock(clock), .arst_n(arst_n), .driveSelect(driveSelect), .driveStrap(3'h1),
		.bitValidReq(bitValidReq), .serialCommandIn(serialCommandIn),
		.readGateFromHost(readGateFromHost), .writeGateFromHost(writeGateFromHost),
		.externalStatusInput(externalStatusInput), .faultClear(faultClear),
		.regAddr(regAddr), .readStrobe(readStrobe), .writeStrobe(writeStrobe),
		.writeData(writeData), .readData(readData), .bitTakenAck(bitTakenAck),
		.statusDataOut(statusDataOut), .alertToHost(alertToHost),
		.commandDone(commandDone), .cmdInterrupt(cmdInterrupt)
	);

	disk_ctrl_model disk_ctrl_model_i (
		.clock(clock), .bitTakenAck(bitTakenAck), .statusDataOut(statusDataOut),
		.bitValidReq(bitValidReq), .serialCommandIn(serialCommandIn)
	);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task tally_and_finish;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
			miscompares++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		regAddr = a;
		writeData = d;
		writeStrobe = 1'b1;
		@(posedge clock);
		#1;
		writeStrobe = 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clock);
		#1;
		regAddr = a;
		readStrobe = 1'b1;
		@(posedge clock);
		#1;
		readStrobe = 1'b0;
		chk(readData, exp);
	endtask

	// bounded wait on the interrupt (done=0) or on command done (done=1)
	task automatic waitHigh(input bit done);
		for (int i = 0; i < 300; i++) begin
			@(posedge clock);
			#1;
			if ((done ? commandDone : cmdInterrupt) === 1'b1) begin
				return;
			end
		end
		$display("mismatch t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
		miscompares++;
		tally_and_finish;
	endtask

	// odd total of ones including the parity bit is the good case
	task automatic sendCmd(input logic [15:0] w);
		disk_ctrl_model_i.frame({w, ~^w}, 17, rx, ok);
		chk(ok, 1'b1);
	endtask

	task automatic pulseClear;
		faultClear = 1'b1;
		cyc(1);
		faultClear = 1'b0;
		cyc(1);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic tConflict;
		driveSelect = 3'h2;
		readGateFromHost = 1'b1;
		writeGateFromHost = 1'b1;
		cyc(2);
		chk(alertToHost, 1'b0);
		driveSelect = 3'h1;
		cyc(2);
		readGateFromHost = 1'b0;
		writeGateFromHost = 1'b0;
		cyc(2);
		chk(alertToHost, 1'b1);
		rd(ADDR_FAULTS, 8'h80);
		sendCmd(16'h1000);
		waitHigh(1'b0);
		rd(ADDR_WORD_LOW, 8'h00);
		rd(ADDR_FAULTS, 8'h80);
		sendCmd(16'h5000);
		waitHigh(1'b0);
		rd(ADDR_WORD_HIGH, 8'h50);
		rd(ADDR_WORD_LOW, 8'h00);
		rd(ADDR_FAULTS, 8'h00);
		chk(alertToHost, 1'b0);
	endtask

	task automatic tDoneReg;
		wr(ADDR_DONE_TRIG, 8'h01);
		cyc(3);
		chk(commandDone, 1'b0);
		wr(ADDR_DONE_TRIG, BYTE_ZERO);
		waitHigh(1'b1);
		rd(ADDR_DONE_TRIG, 8'h00);
		wr(ADDR_FAULTS, 8'hFF);
		rd(ADDR_FAULTS, 8'h00);
	endtask

	task automatic tRequestData;
		sendCmd(16'h2000);
		waitHigh(1'b0);
		chk(commandDone, 1'b0);
		rd(ADDR_WORD_HIGH, 8'h20);
		rd(ADDR_WORD_LOW, 8'h00);
		wr(ADDR_WORD_HIGH, 8'hA5);
		wr(ADDR_WORD_LOW, 8'h3D);
		disk_ctrl_model_i.frame(17'h00000, 17, rx, ok);
		chk(rx, {16'hA53D, ^16'hA53D});
		waitHigh(1'b1);
	endtask

	task automatic tParity;
		disk_ctrl_model_i.frame({16'h1234, ^16'h1234}, 17, rx, ok);
		cyc(6);
		chk(cmdInterrupt, 1'b0);
		chk(alertToHost, 1'b1);
		rd(ADDR_FAULTS, 8'h01);
		pulseClear();
		rd(ADDR_FAULTS, 8'h00);
	endtask

	task automatic tAbort;
		driveSelect = 3'h2;
		disk_ctrl_model_i.xfer(1'b1, rx[0], ok);
		chk(ok, 1'b0);
		driveSelect = 3'h1;
		disk_ctrl_model_i.frame(17'h1FFFF, 5, rx, ok);
		driveSelect = 3'h2;
		cyc(3);
		driveSelect = 3'h1;
		cyc(2);
		rd(ADDR_FAULTS, 8'h10);
		chk(alertToHost, 1'b1);
		pulseClear();
		rd(ADDR_FAULTS, 8'h00);
		sendCmd(16'h7001);
		waitHigh(1'b0);
		rd(ADDR_WORD_HIGH, 8'h70);
		rd(ADDR_WORD_LOW, 8'h01);
	endtask

	task automatic tStatus;
		externalStatusInput = 1'b1;
		cyc(3);
		chk(alertToHost, 1'b1);
		externalStatusInput = 1'b0;
		cyc(3);
		chk(alertToHost, 1'b0);
	endtask

	// one word in the registers, four in the fifo, the sixth refused
	task automatic tFifo;
		for (int i = 0; i < 5; i++) begin
			sendCmd({8'h11, 8'(i)});
		end
		disk_ctrl_model_i.frame({16'h1199, ~^16'h1199}, 17, rx, ok);
		chk(ok, 1'b0);
		for (int i = 0; i < 5; i++) begin
			waitHigh(1'b0);
			rd(ADDR_WORD_HIGH, 8'h11);
			rd(ADDR_WORD_LOW, 8'(i));
		end
	endtask

	initial begin
		miscompares = 0;
		cmp_count = 0;
		arst_n = 1'b0;
		driveSelect = 3'h1;
		readGateFromHost = 1'b0;
		writeGateFromHost = 1'b0;
		externalStatusInput = 1'b0;
		faultClear = 1'b0;
		regAddr = 2'h0;
		readStrobe = 1'b0;
		writeStrobe = 1'b0;
		writeData = 8'h00;
		repeat (12) @(posedge clock);
		#1;
		arst_n = 1'b1;
		cyc(1);
		chk({alertToHost, commandDone, cmdInterrupt}, 3'h0);
		tConflict();
		tDoneReg();
		tRequestData();
		tParity();
		tAbort();
		tStatus();
		tFifo();
		tally_and_finish;
	end
endmodule
